// File: logic/tli_top.sv
// Message transmitter with two-level completion interrupt and Avalon-MM registers
// What this block does
// - Transmit interrupts pass only through both a block enable and a source enable.
// - Block transmit enable is bit 1 of register 0x04; 1 enables, 0 disables.
// - Block enable at 0 suppresses every transmit interrupt whatever the source enables.
// - With block enable 1, a source interrupts only when its own enable is 1.
// - Completion interrupt enable is bit 1 of register 0x34.
// - Completion sets status bit 0 of register 0x34; reading that register clears it.
// - A generated completion interrupt drives the active-low interrupt output low.
// - On start, compute 16-bit check sequence over buffer 0x86..0xDB and append it.
// - Insert a 0 after every five consecutive 1s, except in the byte at 0x86.
// - After stuffing, append a closing flag byte 0x7E.
// - Send the frame serially inside the overhead byte of each outbound frame.
// - The send sequence begins only upon the host's start command.
// - When the whole frame is sent, raise completion and accept the next message.
`timescale 1ns/1ps

module tli_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} tli_fifo_st_t;
	tli_fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	// Full and empty come straight from the occupancy count
	assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data = mem[s_q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer wrap relies on DEPTH being a power of two
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[s_q.wr] <= in_data;
		end
	end
endmodule

module tli_top #(
	parameter int FIFO_DEPTH = tli_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire tli_pkg::tli_bus_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Overhead byte slot of the outbound frame
	input wire logic oh_slot,
	output tli_pkg::tli_oh_t oh_out,
	// Interrupt
	output logic int_n
);
	typedef struct packed {
		logic blk_rx_en;
		logic blk_tx_en;
		logic blk_sec_en;
		logic done_en;
		logic done_flag;
		logic start;
		logic busy;
		tli_pkg::tli_seq_t st;
		logic [6:0] idx;
		logic [2:0] bit_idx;
		logic [2:0] ones;
		logic [15:0] fcs;
		logic [7:0] pk_sr;
		logic [2:0] pk_cnt;
		logic wait_q;
		logic [31:0] rdata;
		tli_pkg::tli_oh_t oh;
		logic int_n;
	} tli_st_t;
	tli_st_t s_q, s_d;

	logic [7:0] msg_buf [tli_pkg::MSG_BUF_LEN];
	logic [7:0] cur_byte, push_data, fifo_data;
	logic [15:0] fcs_out;
	logic emit, emit_bit, emit_ok, push, done;
	logic fifo_in_ready, fifo_out_valid;
	logic acc, req, buf_hit, buf_we;
	logic [6:0] buf_idx;

	// Byte-wise reflected check sequence update, low bit first as on the line
	function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ tli_pkg::FCS_POLY_REFL) : (r >> 1);
		end
		return r;
	endfunction

	// Bus decode; an access is taken on the edge where waitrequest is low
	assign req = avs_req.read || avs_req.write;
	assign acc = req && !s_q.wait_q;
	assign buf_hit = (avs_req.address >= tli_pkg::MSG_BUF_FIRST_IDX)
		&& (avs_req.address <= tli_pkg::MSG_BUF_LAST_IDX);
	assign buf_idx = 7'(avs_req.address - tli_pkg::MSG_BUF_FIRST_IDX);
	assign buf_we = acc && avs_req.write && buf_hit && avs_req.byteenable[0];

	// Byte under the serialiser: buffer, then check sequence low byte first
	assign fcs_out = ~s_q.fcs;
	always_comb begin
		if (s_q.idx < 7'(tli_pkg::MSG_BUF_LEN)) begin
			cur_byte = msg_buf[s_q.idx];
		end else if (s_q.idx == 7'(tli_pkg::MSG_BUF_LEN)) begin
			cur_byte = fcs_out[7:0];
		end else begin
			cur_byte = fcs_out[15:8];
		end
	end

	// A bit that completes a byte may only go when the FIFO can take it
	assign emit_ok = (s_q.pk_cnt != 3'h7) || fifo_in_ready;
	assign done = (s_q.st == tli_pkg::seq_drain) && !fifo_out_valid;

	always_comb begin
		s_d = s_q;
		emit = 1'b0;
		emit_bit = 1'b1;
		push = 1'b0;
		push_data = {1'b1, s_q.pk_sr[7:1]};
		// Handshake: one wait cycle, then one answer cycle
		s_d.wait_q = 1'b1;
		if (req && s_q.wait_q) begin
			s_d.wait_q = 1'b0;
			s_d.rdata = 32'h0000_0000;
			if (avs_req.address == tli_pkg::BLK_IRQ_EN_IDX) begin
				s_d.rdata[tli_pkg::BLK_RX_EN_BIT] = s_q.blk_rx_en;
				s_d.rdata[tli_pkg::BLK_TX_EN_BIT] = s_q.blk_tx_en;
				s_d.rdata[tli_pkg::BLK_SEC_EN_BIT] = s_q.blk_sec_en;
			end else if (avs_req.address == tli_pkg::TX_MSG_STAT_IDX) begin
				s_d.rdata[tli_pkg::MSG_SEND_CMD_BIT] = s_q.start;
				s_d.rdata[tli_pkg::MSG_SEND_ACTIVE_BIT] = s_q.busy;
				s_d.rdata[tli_pkg::MSG_DONE_EN_BIT] = s_q.done_en;
				s_d.rdata[tli_pkg::MSG_DONE_FLAG_BIT] = s_q.done_flag;
			end else if (buf_hit) begin
				s_d.rdata[7:0] = msg_buf[buf_idx];
			end
		end
		// Register writes take effect at the accepting edge
		if (acc && avs_req.write && avs_req.byteenable[0]) begin
			if (avs_req.address == tli_pkg::BLK_IRQ_EN_IDX) begin
				s_d.blk_rx_en = avs_req.writedata[tli_pkg::BLK_RX_EN_BIT];
				s_d.blk_tx_en = avs_req.writedata[tli_pkg::BLK_TX_EN_BIT];
				s_d.blk_sec_en = avs_req.writedata[tli_pkg::BLK_SEC_EN_BIT];
			end else if (avs_req.address == tli_pkg::TX_MSG_STAT_IDX) begin
				s_d.done_en = avs_req.writedata[tli_pkg::MSG_DONE_EN_BIT];
				// A start while busy is dropped; it cannot restart a frame mid-flight
				if (avs_req.writedata[tli_pkg::MSG_SEND_CMD_BIT] && !s_q.busy) begin
					s_d.start = 1'b1;
				end
			end
		end
		// Clear only a flag the reader actually saw; a new set below still wins
		if (acc && avs_req.read && (avs_req.address == tli_pkg::TX_MSG_STAT_IDX)
			&& s_q.rdata[tli_pkg::MSG_DONE_FLAG_BIT]) begin
			s_d.done_flag = 1'b0;
		end
		// Message sequence
		unique case (s_q.st)
			tli_pkg::seq_idle: begin
				if (s_q.start) begin
					s_d.st = tli_pkg::seq_fcs;
					s_d.busy = 1'b1;
					s_d.idx = 7'h00;
					s_d.fcs = tli_pkg::FCS_INIT;
				end
			end
			tli_pkg::seq_fcs: begin
				s_d.fcs = fcs_step(s_q.fcs, msg_buf[s_q.idx]);
				s_d.idx = s_q.idx + 7'h01;
				if (s_q.idx == 7'(tli_pkg::MSG_BUF_LEN - 1)) begin
					s_d.st = tli_pkg::seq_bits;
					s_d.idx = 7'h00;
					s_d.bit_idx = 3'h0;
					s_d.ones = 3'h0;
					s_d.pk_cnt = 3'h0;
				end
			end
			tli_pkg::seq_bits, tli_pkg::seq_flag: begin
				if (emit_ok) begin
					emit = 1'b1;
					if (s_q.ones == tli_pkg::STUFF_RUN) begin
						emit_bit = 1'b0;
						s_d.ones = 3'h0;
					end else if (s_q.st == tli_pkg::seq_flag) begin
						emit_bit = tli_pkg::HDLC_FLAG[s_q.bit_idx];
						s_d.bit_idx = s_q.bit_idx + 3'h1;
						if (s_q.bit_idx == 3'h7) begin
							s_d.st = (s_q.pk_cnt == 3'h7) ? tli_pkg::seq_drain : tli_pkg::seq_pad;
						end
					end else begin
						emit_bit = cur_byte[s_q.bit_idx];
						// Opening flag byte is neither counted nor stuffed
						if (s_q.idx == 7'h00 || !emit_bit) begin
							s_d.ones = 3'h0;
						end else begin
							s_d.ones = s_q.ones + 3'h1;
						end
						s_d.bit_idx = s_q.bit_idx + 3'h1;
						if (s_q.bit_idx == 3'h7) begin
							s_d.idx = s_q.idx + 7'h01;
							if (s_q.idx == 7'(tli_pkg::MSG_BUF_LEN + 1)) begin
								s_d.st = tli_pkg::seq_flag;
							end
						end
					end
				end
			end
			tli_pkg::seq_pad: begin
				// Fill the last partial byte with ones, which reads as idle line
				if (emit_ok) begin
					emit = 1'b1;
					emit_bit = 1'b1;
					if (s_q.pk_cnt == 3'h7) begin
						s_d.st = tli_pkg::seq_drain;
					end
				end
			end
			tli_pkg::seq_drain: begin
				if (done) begin
					s_d.st = tli_pkg::seq_idle;
					s_d.busy = 1'b0;
					s_d.start = 1'b0;
					s_d.done_flag = 1'b1;
				end
			end
			default: begin
				s_d.st = tli_pkg::seq_idle;
				s_d.busy = 1'b0;
			end
		endcase
		// Pack bits low first into bytes for the FIFO
		if (emit) begin
			s_d.pk_sr = {emit_bit, s_q.pk_sr[7:1]};
			s_d.pk_cnt = s_q.pk_cnt + 3'h1;
			if (s_q.pk_cnt == 3'h7) begin
				push = 1'b1;
				push_data = {emit_bit, s_q.pk_sr[7:1]};
			end
		end
		// One byte per overhead slot; idle flags when nothing is queued
		s_d.oh.valid = oh_slot;
		if (oh_slot) begin
			s_d.oh.data = fifo_out_valid ? fifo_data : tli_pkg::HDLC_FLAG;
		end
		// Both enable levels must be set for the flag to pull the line low
		s_d.int_n = !(s_d.blk_tx_en && s_d.done_en && s_d.done_flag);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.blk_tx_en <= tli_pkg::BLK_TX_EN_RST;
			s_q.done_en <= tli_pkg::MSG_DONE_EN_RST;
			s_q.st <= tli_pkg::seq_idle;
			s_q.wait_q <= 1'b1;
			s_q.int_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Message buffer, written from the bus only
	always_ff @(posedge ref_clk) begin
		if (buf_we) begin
			msg_buf[buf_idx] <= avs_req.writedata[7:0];
		end
	end

	tli_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(fifo_out_valid),
		.out_ready(oh_slot),
		.out_data(fifo_data)
	);

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.wait_q;
	assign oh_out = s_q.oh;
	assign int_n = s_q.int_n;

	// Checks
	a_block_gate_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!s_q.blk_tx_en |-> int_n) else $error("irq seen with block enable off");
	a_source_gate_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_q.blk_tx_en && !s_q.done_en) |-> int_n) else $error("irq seen with source off");
	a_irq_low_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_q.blk_tx_en && s_q.done_en && s_q.done_flag) |-> !int_n)
		else $error("irq not low while enabled flag set");
	a_blk_en_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(acc && avs_req.write && avs_req.byteenable[0]
		&& avs_req.address == tli_pkg::BLK_IRQ_EN_IDX)
		|=> s_q.blk_tx_en == $past(avs_req.writedata[tli_pkg::BLK_TX_EN_BIT]))
		else $error("block enable lost");
	a_src_en_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(acc && avs_req.write && avs_req.byteenable[0]
		&& avs_req.address == tli_pkg::TX_MSG_STAT_IDX)
		|=> s_q.done_en == $past(avs_req.writedata[tli_pkg::MSG_DONE_EN_BIT]))
		else $error("source enable lost");
	a_done_flag_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
		done |=> (s_q.done_flag && !s_q.busy && s_q.st == tli_pkg::seq_idle))
		else $error("completion not flagged");
	a_flag_read_clr: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(acc && avs_req.read && avs_req.address == tli_pkg::TX_MSG_STAT_IDX
		&& s_q.rdata[tli_pkg::MSG_DONE_FLAG_BIT] && !done)
		|=> !s_q.done_flag) else $error("flag not cleared by read");
	a_start_only_cmd: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s_q.st == tli_pkg::seq_idle && !s_q.start) |=> s_q.st == tli_pkg::seq_idle)
		else $error("send began without start");
	a_fcs_span: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(s_q.st == tli_pkg::seq_fcs) |-> ##86 s_q.st == tli_pkg::seq_bits)
		else $error("check sequence span wrong");
	a_zero_insert: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(emit && s_q.ones == tli_pkg::STUFF_RUN && s_q.st != tli_pkg::seq_pad) |-> !emit_bit)
		else $error("missing stuffed zero");
	a_busy_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_q.busy == (s_q.st != tli_pkg::seq_idle)) else $error("busy disagrees");
	a_slot_byte: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(oh_slot && fifo_out_valid) |=> (oh_out.valid && oh_out.data == $past(fifo_data)))
		else $error("overhead byte not sent");
	c_msg_done: cover property (@(posedge ref_clk) disable iff (!reset_n) done);
	c_irq_low: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(int_n));
	c_stuffed: cover property (@(posedge ref_clk) disable iff (!reset_n)
		emit && s_q.ones == 3'h5);
	c_fifo_full: cover property (@(posedge ref_clk) disable iff (!reset_n) !fifo_in_ready);
endmodule

// File: logic/tli_pkg.sv
// Package: register map, field layout, sequence states and carriers for the message transmitter
package tli_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] BLK_IRQ_EN_IDX = 8'h04;
	localparam logic [7:0] TX_MSG_STAT_IDX = 8'h34;
	localparam logic [7:0] MSG_BUF_FIRST_IDX = 8'h86;
	localparam logic [7:0] MSG_BUF_LAST_IDX = 8'hDB;
	localparam int MSG_BUF_LEN = 86;
	// Field positions in the block enable register
	localparam int BLK_RX_EN_BIT = 7;
	localparam int BLK_TX_EN_BIT = 1;
	localparam int BLK_SEC_EN_BIT = 0;
	// Field positions in the message status register
	localparam int MSG_SEND_CMD_BIT = 3;
	localparam int MSG_SEND_ACTIVE_BIT = 2;
	localparam int MSG_DONE_EN_BIT = 1;
	localparam int MSG_DONE_FLAG_BIT = 0;
	// Reset values
	localparam logic BLK_TX_EN_RST = 1'b0;
	localparam logic MSG_DONE_EN_RST = 1'b0;
	// Frame check sequence and framing constants
	localparam logic [15:0] FCS_INIT = 16'hFFFF;
	localparam logic [15:0] FCS_POLY_REFL = 16'h8408;
	localparam logic [7:0] HDLC_FLAG = 8'h7E;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		seq_idle = 3'b000,
		seq_fcs = 3'b001,
		seq_bits = 3'b010,
		seq_flag = 3'b011,
		seq_pad = 3'b100,
		seq_drain = 3'b101
	} tli_seq_t;

	// Avalon-MM request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} tli_bus_req_t;

	// Byte handed to the framer for one overhead slot
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} tli_oh_t;
endpackage

// File: dv/tli_slot_model.sv
// Framer overhead slot model: asks for one byte per outbound frame and records it
`timescale 1ns/1ps
module tli_slot_model #(
	parameter int PERIOD = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Bench control
	input wire logic en,
	// Overhead slot
	output logic oh_slot,
	input wire tli_pkg::tli_oh_t oh_out
);
	logic [7:0] got[$];
	int cnt;

	// Idle state at time zero
	initial begin
		oh_slot = 1'b0;
		cnt = 0;
	end

	// Fixed frame rate; a real framer never waits for the transmitter
	always @(posedge ref_clk) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		oh_slot <= en && reset_n && cnt == 0;
	end

	// Sampled mid-cycle so the byte has settled
	always @(negedge ref_clk) begin
		if (oh_out.valid === 1'b1) begin
			got.push_back(oh_out.data);
		end
	end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the message transmitter and its completion interrupt
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s expected %0h seen %0h", nm, (e), (g)); end end

module testbench;
	logic ref_clk;
	logic reset_n;
	tli_pkg::tli_bus_req_t avs_req;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic oh_slot;
	tli_pkg::tli_oh_t oh_out;
	logic int_n;
	logic slot_en;
	logic saw_low;
	int mismatches;
	int n_compared;
	logic [7:0] bufv[86];
	logic [7:0] exp_q[$];
	logic [31:0] rd;
	int k;

	tli_top #(.FIFO_DEPTH(16)) dut_u (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.avs_req(avs_req),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.oh_slot(oh_slot),
		.oh_out(oh_out),
		.int_n(int_n)
	);

	tli_slot_model #(.PERIOD(16)) slot_u (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.en(slot_en),
		.oh_slot(oh_slot),
		.oh_out(oh_out)
	);

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Sticky record of any interrupt assertion
	always @(negedge ref_clk) begin
		if (int_n === 1'b0) saw_low = 1'b1;
	end

	task automatic close_out;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One Avalon access; request held until the rising edge that sees waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		avs_req <= {!w, w, a, 24'h000000, d, 4'hF};
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		rd = avs_readdata;
		avs_req <= '0;
		// Idle edge so a following call never rewrites the request in this step
		@(posedge ref_clk);
	endtask

	// Expected wire bytes: check sequence, stuffing, closing flag, 1-padding
	task automatic build;
		logic [15:0] c;
		logic [7:0] v;
		logic b[$];
		int i, j, run;
		c = tli_pkg::FCS_INIT;
		for (i = 0; i < tli_pkg::MSG_BUF_LEN; i++) begin
			c = c ^ {8'h00, bufv[i]};
			for (j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ tli_pkg::FCS_POLY_REFL) : (c >> 1);
		end
		c = ~c;
		run = 0;
		for (i = 0; i < tli_pkg::MSG_BUF_LEN + 2; i++) begin
			v = (i < tli_pkg::MSG_BUF_LEN) ? bufv[i] : (i == tli_pkg::MSG_BUF_LEN ? c[7:0] : c[15:8]);
			for (j = 0; j < 8; j++) begin
				b.push_back(v[j]);
				run = (v[j] && i > 0) ? run + 1 : 0;
				if (run == 5) begin
					b.push_back(1'b0);
					run = 0;
				end
			end
		end
		for (j = 0; j < 8; j++) b.push_back(tli_pkg::HDLC_FLAG[j]);
		while (b.size() % 8 != 0) b.push_back(1'b1);
		for (i = 0; i < b.size(); i++) begin
			v[i % 8] = b[i];
			if (i % 8 == 7) exp_q.push_back(v);
		end
	endtask

	// One message under the given enables; kill drops the block enable while pending
	task automatic run_msg(input logic blk, input logic src, input logic kill);
		int n;
		int i;
		saw_low = 1'b0;
		slot_u.got.delete();
		slot_en <= 1'b1;
		bus(1'b1, 8'h04, {6'h00, blk, 1'b0});
		bus(1'b1, 8'h34, {6'h02, src, 1'b0});
		bus(1'b0, 8'h34, 8'h00);
		`CHK("busy", {6'h03, src, 1'b0}, rd[7:0])
		if (blk && src) begin
			while (int_n !== 1'b0) @(posedge ref_clk);
			slot_en <= 1'b0;
			@(posedge ref_clk);
			`CHK("int_n held", 1'b0, int_n)
			if (kill) begin
				bus(1'b1, 8'h04, 8'h00);
				`CHK("int_n masked", 1'b1, int_n)
				bus(1'b0, 8'h34, 8'h00);
				`CHK("flag", 8'h03, rd[7:0])
			end else begin
				bus(1'b0, 8'h34, 8'h00);
				`CHK("flag", 8'h03, rd[7:0])
				`CHK("int_n release", 1'b1, int_n)
			end
		end else begin
			// Polling only; the flag read must be the one that ends the wait
			do bus(1'b0, 8'h34, 8'h00); while (rd[2] === 1'b1);
			slot_en <= 1'b0;
			`CHK("flag", {6'h00, src, 1'b1}, rd[7:0])
			`CHK("int_n quiet", 1'b0, saw_low)
		end
		bus(1'b0, 8'h34, 8'h00);
		`CHK("cleared", {6'h00, src, 1'b0}, rd[7:0])
		// Only the tail is judged: idle fill bytes lead the frame
		n = slot_u.got.size() - exp_q.size();
		for (i = 0; i < exp_q.size(); i++) `CHK("frame byte", exp_q[i], slot_u.got[n + i])
	endtask

	// Reset values, stored enable bits and unmapped space
	task automatic check_regs;
		`CHK("int_n idle", 1'b1, int_n)
		bus(1'b0, 8'h04, 8'h00);
		`CHK("blk reset", 8'h00, rd[7:0])
		bus(1'b0, 8'h34, 8'h00);
		`CHK("stat reset", 8'h00, rd[7:0])
		bus(1'b1, 8'h04, 8'hFF);
		bus(1'b0, 8'h04, 8'h00);
		`CHK("blk rw", 8'h83, rd[7:0])
		bus(1'b1, 8'h10, 8'hFF);
		bus(1'b0, 8'h10, 8'h00);
		`CHK("unmapped", 32'h00000000, rd)
	endtask

	// Fill the message buffer, read one byte back, then build the expected wire bytes
	task automatic load_buf;
		for (k = 0; k < tli_pkg::MSG_BUF_LEN; k++) begin
			bufv[k] = (k == 0) ? tli_pkg::HDLC_FLAG : (k[0] ? 8'hFF : 8'(k * 19));
			bus(1'b1, 8'(8'h86 + k), bufv[k]);
		end
		bus(1'b0, 8'h8A, 8'h00);
		`CHK("buf rd", bufv[4], rd[7:0])
		build();
	endtask

	// Main sequence
	initial begin
		avs_req = '0;
		reset_n = 1'b0;
		slot_en = 1'b0;
		saw_low = 1'b0;
		mismatches = 0;
		n_compared = 0;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		check_regs();
		load_buf();
		run_msg(1'b1, 1'b1, 1'b0);
		run_msg(1'b0, 1'b1, 1'b0);
		run_msg(1'b1, 1'b0, 1'b0);
		run_msg(1'b1, 1'b1, 1'b1);
		close_out();
	end

	// Four messages need well under 10000 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		close_out();
	end
endmodule
